// File: src/quad_pkg.sv
// Purpose: shared constants for the quadrature count readout and its host
// Assumes: one clock, both edges used; reset is active high
// Notes:   widths and counts below are the defaults of both ends

package quad_pkg;

   // widths
   localparam int POS_WIDTH  = 16;
   localparam int BYTE_WIDTH = 8;
   localparam int EXT_WIDTH  = 8;

   // input filter: level must be seen on this many rising edges
   localparam int FILTER_LEN = 3;

   // clock
   localparam int CLK_PERIOD_NS = 8;

   // reset values
   localparam logic [POS_WIDTH-1:0]  POS_RESET  = 16'h0000;
   localparam logic [BYTE_WIDTH-1:0] BYTE_RESET = 8'h00;
   localparam logic [EXT_WIDTH-1:0]  EXT_RESET  = 8'h00;

   // byte positions inside the latched word
   localparam int HIGH_BYTE_LSB = 8;
   localparam int LOW_BYTE_LSB  = 0;

   // wrap points of the position counter
   localparam logic [POS_WIDTH-1:0] POS_TOP    = 16'hffff;
   localparam logic [POS_WIDTH-1:0] POS_BOTTOM = 16'h0000;

endpackage

// File: src/quad_link_if.sv
// Purpose: pins between the readout device and its host
// Assumes: both ends share core_clk, supplied by the bench
// Notes:   data_oe high means the device drives data; bench resolves bus

`timescale 1ns/1ps

interface quad_link_if;
   import quad_pkg::*;

   // read control, driven by the host
   logic                  oe_n;
   logic                  byte_sel;
   // data bus, driven by the device
   logic [BYTE_WIDTH-1:0] data;
   logic                  data_oe;
   // count outputs, driven by the device
   logic                  decode_count_pulse;
   logic                  wrap_cascade_pulse;
   logic                  count_up;

   modport dev
   (
      input  oe_n, byte_sel,
      output data, data_oe, decode_count_pulse, wrap_cascade_pulse, count_up
   );

   modport host
   (
      output oe_n, byte_sel,
      input  data, data_oe, decode_count_pulse, wrap_cascade_pulse, count_up
   );

endinterface // quad_link_if

// File: src/quad_count_device.sv
// Purpose: quadrature decoder, position counter, latch, inhibit and bus
// Assumes: phase inputs and host pins are synchronous to core_clk
// Notes:   inhibit, pulse follower and bus flops work on the falling edge where
//          the behaviour needs half-cycle placement

`timescale 1ns/1ps

module quad_count_device
   import quad_pkg::*;
#(
   parameter int FILT_LEN = quad_pkg::FILTER_LEN
)
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // encoder phases
   input  wire logic phase_a_in,
   input  wire logic phase_b_in,
   // link to host
   quad_link_if.dev  link
);
   import quad_pkg::*;

   // elaboration checks
   if (FILT_LEN < 1 || FILT_LEN > 8)
   begin : g_bad_filt
      $error("FILT_LEN must be 1 to 8");
   end
   if (POS_WIDTH != 2 * BYTE_WIDTH)
   begin : g_bad_width
      $error("position must be exactly two bytes");
   end

   // filter history and filtered phases
   logic [FILT_LEN-1:0] hist_reg [2];
   logic [FILT_LEN:0]   hist_next [2];
   logic [1:0]          filt_reg;
   logic [1:0]          filt_prev_reg;
   logic [1:0]          phase_in;

   // decoder stage
   logic                step_reg;
   logic                dir_reg;
   logic                step_next;
   logic                dir_next;

   // counter, latch, inhibit
   logic [POS_WIDTH-1:0] count_reg;
   logic [POS_WIDTH-1:0] latch_reg;
   logic                 inhibit_reg;
   logic                 wrap_now;

   // pulse toggles: rise flop flips on posedge, fall flop follows on negedge
   logic dec_rise_reg;
   logic dec_fall_reg;
   logic cas_rise_reg;
   logic cas_fall_reg;

   // bus output flops
   logic [BYTE_WIDTH-1:0] data_reg;
   logic                  data_oe_reg;

   assign phase_in = {phase_b_in, phase_a_in};

   // per-phase stability filter; with FILT_LEN above one a lone glitch never reaches the decoder
   for (genvar ch = 0; ch < 2; ch++)
   begin : g_filt
      // newest sample enters at bit 0; one spare top bit keeps a length of one legal
      assign hist_next[ch] = {hist_reg[ch], phase_in[ch]};

      always_ff @(posedge core_clk)
      begin
         if (reset)
         begin
            hist_reg[ch]    <= '0;
            filt_reg[ch]    <= 1'b0;
            filt_prev_reg[ch] <= 1'b0;
         end
         else
         begin
            hist_reg[ch] <= hist_next[ch][FILT_LEN-1:0];
            // change only once the level stood on every sample
            if (&hist_reg[ch])
            begin
               filt_reg[ch] <= 1'b1;
            end
            else if (~|hist_reg[ch])
            begin
               filt_reg[ch] <= 1'b0;
            end
            filt_prev_reg[ch] <= filt_reg[ch];
         end
      end
   end

   // 4x decode: one bit changed is a step; a xor old b gives direction
   always_comb
   begin
      step_next = (filt_reg[0] ^ filt_prev_reg[0]) ^ (filt_reg[1] ^ filt_prev_reg[1]);
      dir_next  = filt_reg[0] ^ filt_prev_reg[1];
   end

   // decoder stage register; direction changes a cycle ahead of the pulse
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         step_reg <= 1'b0;
         dir_reg  <= 1'b1;
      end
      else
      begin
         step_reg <= step_next;
         if (step_next)
         begin
            dir_reg <= dir_next;
         end
      end
   end

   // wrap occurs when stepping past either end of the range
   assign wrap_now = step_reg & (dir_reg ? (count_reg == POS_TOP) : (count_reg == POS_BOTTOM));

   // position counter; never looks at the inhibit
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         count_reg <= POS_RESET;
      end
      else if (step_reg)
      begin
         if (dir_reg)
         begin
            count_reg <= count_reg + 16'h0001;
         end
         else
         begin
            count_reg <= count_reg - 16'h0001;
         end
      end
   end

   // rising half of the pulses, same edge as the counter update
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         dec_rise_reg <= 1'b0;
         cas_rise_reg <= 1'b0;
      end
      else
      begin
         if (step_reg)
         begin
            dec_rise_reg <= ~dec_rise_reg;
         end
         if (wrap_now)
         begin
            cas_rise_reg <= ~cas_rise_reg;
         end
      end
   end

   // falling half: follower catches up, ending the pulse mid-cycle
   always_ff @(negedge core_clk)
   begin
      if (reset)
      begin
         dec_fall_reg <= 1'b0;
         cas_fall_reg <= 1'b0;
      end
      else
      begin
         dec_fall_reg <= dec_rise_reg;
         cas_fall_reg <= cas_rise_reg;
      end
   end

   // pulse is the gap between the two toggles; an xor, not a flop, so the
   // width is exactly the high phase of the clock
   assign link.decode_count_pulse = dec_rise_reg ^ dec_fall_reg;
   assign link.wrap_cascade_pulse = cas_rise_reg ^ cas_fall_reg;
   assign link.count_up           = dir_reg;

   // position latch; async clear so reset frees it at once
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         latch_reg <= POS_RESET;
      end
      else if (!inhibit_reg)
      begin
         latch_reg <= count_reg;
      end
   end

   // inhibit: host pins are only looked at on the falling edge
   always_ff @(negedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         inhibit_reg <= 1'b0;
      end
      else if (link.oe_n)
      begin
         inhibit_reg <= 1'b0;
      end
      else if (!link.byte_sel)
      begin
         inhibit_reg <= 1'b1;
      end
      // select high with enable low keeps the state; held high it never sets
      else
      begin
         inhibit_reg <= inhibit_reg;
      end
   end

   // byte mux and enable, placed on the same edge as the inhibit sample so
   // the byte shown is the one the inhibit protects
   always_ff @(negedge core_clk)
   begin
      if (reset)
      begin
         data_reg    <= BYTE_RESET;
         data_oe_reg <= 1'b0;
      end
      else
      begin
         data_oe_reg <= ~link.oe_n;
         if (link.oe_n)
         begin
            data_reg <= BYTE_RESET;
         end
         else if (!link.byte_sel)
         begin
            data_reg <= latch_reg[HIGH_BYTE_LSB +: BYTE_WIDTH];
         end
         else
         begin
            data_reg <= latch_reg[LOW_BYTE_LSB +: BYTE_WIDTH];
         end
      end
   end

   assign link.data    = data_reg;
   assign link.data_oe = data_oe_reg;

endmodule // quad_count_device

// File: src/quad_bus_host.sv
// Purpose: host end: runs byte reads and keeps the external cascade count
// Assumes: same core_clk as the device
// Notes:   read pins change on rising edges, so they are stable at the
//          device's falling-edge sample

`timescale 1ns/1ps

module quad_bus_host
   import quad_pkg::*;
#(
   parameter int EXT_W = quad_pkg::EXT_WIDTH
)
(
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   // user request
   input  wire logic                   read_start,
   input  wire logic                   two_byte,
   // user answer
   output logic                        read_done,
   output logic [POS_WIDTH-1:0]        read_pos,
   output logic [EXT_W-1:0]            read_ext,
   // link to device
   quad_link_if.host                   link
);
   import quad_pkg::*;

   if (EXT_W < 1 || EXT_W > 32)
   begin : g_bad_ext
      $error("EXT_W must be 1 to 32");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW, ST_END} host_state_t;

   host_state_t           state_reg;
   logic                  oe_n_reg;
   logic                  sel_reg;
   logic                  done_reg;
   logic [POS_WIDTH-1:0]  pos_reg;
   logic [EXT_W-1:0]      ext_count_reg;
   logic [EXT_W-1:0]      ext_latch_reg;

   // read sequencer; pins move only on the rising edge
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_reg <= ST_IDLE;
         oe_n_reg  <= 1'b1;
         sel_reg   <= 1'b1;
         done_reg  <= 1'b0;
         pos_reg   <= POS_RESET;
      end
      else
      begin
         done_reg <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (read_start)
               begin
                  oe_n_reg  <= 1'b0;
                  sel_reg   <= ~two_byte;
                  state_reg <= two_byte ? ST_HIGH : ST_LOW;
               end
            end
            ST_HIGH:
            begin
               pos_reg[HIGH_BYTE_LSB +: BYTE_WIDTH] <= link.data;
               sel_reg   <= 1'b1;
               state_reg <= ST_LOW;
            end
            ST_LOW:
            begin
               pos_reg[LOW_BYTE_LSB +: BYTE_WIDTH] <= link.data;
               if (sel_reg && oe_n_reg == 1'b0 && state_reg == ST_LOW && !two_byte)
               begin
                  pos_reg[HIGH_BYTE_LSB +: BYTE_WIDTH] <= BYTE_RESET;
               end
               oe_n_reg  <= 1'b1;
               state_reg <= ST_END;
            end
            ST_END:
            begin
               done_reg  <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // external cascade counter, sampled on the falling edge that ends the pulse
   always_ff @(negedge core_clk)
   begin
      if (reset)
      begin
         ext_count_reg <= EXT_W'(EXT_RESET);
         ext_latch_reg <= EXT_W'(EXT_RESET);
      end
      else
      begin
         if (link.wrap_cascade_pulse)
         begin
            ext_count_reg <= link.count_up ? ext_count_reg + 1'b1 : ext_count_reg - 1'b1;
         end
         // freeze at high-byte start, before the pulse of that cycle lands
         if (state_reg == ST_HIGH)
         begin
            ext_latch_reg <= ext_count_reg;
         end
      end
   end

   assign link.oe_n     = oe_n_reg;
   assign link.byte_sel = sel_reg;
   assign read_done     = done_reg;
   assign read_pos      = pos_reg;
   assign read_ext      = ext_latch_reg;

endmodule // quad_bus_host

// File: dv/quad_link_props.sv
// Purpose: timing relations on the link between readout device and host
// Assumes: one clock; host pins move only on rising edges
// Notes:   pulses are high only from rising to falling edge

`timescale 1ns/1ps

module quad_link_props
(
   // clock and reset
   input wire logic                          core_clk,
   input wire logic                          reset,
   // read control from host
   input wire logic                          oe_n,
   input wire logic                          byte_sel,
   // device outputs
   input wire logic [quad_pkg::BYTE_WIDTH-1:0] data,
   input wire logic                          data_oe,
   input wire logic                          decode_count_pulse,
   input wire logic                          wrap_cascade_pulse,
   input wire logic                          count_up
);
   import quad_pkg::*;

   // falling-edge checks name their own clock
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // bus drive follows the enable seen at the last fall
   a_bus_drive: assert property (!oe_n |-> data_oe)
      else $error("data not driven while enabled");
   a_bus_release: assert property (oe_n |-> !data_oe)
      else $error("data driven while disabled");
   a_data_idle: assert property (!data_oe |-> data == BYTE_RESET)
      else $error("data not cleared when released");

   // pulses must be gone before every rising edge
   a_decode_half: assert property (!decode_count_pulse)
      else $error("decode pulse longer than half a cycle");
   a_cascade_half: assert property (!wrap_cascade_pulse)
      else $error("cascade pulse longer than half a cycle");
   a_wrap_counted: assert property (@(negedge core_clk) wrap_cascade_pulse |-> decode_count_pulse)
      else $error("cascade pulse without a count");
   a_dir_held: assert property (@(negedge core_clk)
      decode_count_pulse |-> $stable(count_up) ##1 $stable(count_up))
      else $error("direction moved around a pulse");

   // read walks: high byte, low byte, release; or low byte alone, release
   a_two_byte_walk: assert property ($fell(oe_n) && !byte_sel |=> !oe_n && byte_sel ##1 oe_n)
      else $error("two byte read out of order");
   a_one_byte_walk: assert property ($fell(oe_n) && byte_sel |=> oe_n && byte_sel)
      else $error("one byte read out of order");
   a_sel_idle_high: assert property (!byte_sel |-> !oe_n)
      else $error("select low outside a read");

endmodule // quad_link_props

// File: dv/quadrature_count_readout_bench.sv
// Purpose: random walks and reads through both ends of the readout link
// Assumes: phase steps spaced four cycles, longer than the input filter
// Notes:   reads during motion must return one whole counted value

`timescale 1ns/1ps

module quadrature_count_readout_bench;
   import quad_pkg::*;

   logic                  core_clk   = 1'b0;
   logic                  reset      = 1'b1;
   logic                  phase_a_in = 1'b0;
   logic                  phase_b_in = 1'b0;
   logic                  read_start = 1'b0;
   logic                  two_byte   = 1'b1;
   logic                  read_done;
   logic [POS_WIDTH-1:0]  read_pos;
   logic [EXT_WIDTH-1:0]  read_ext;
   logic [POS_WIDTH-1:0]  exp_pos    = POS_RESET;
   logic [EXT_WIDTH-1:0]  exp_ext    = EXT_RESET;
   logic [1:0]            state      = 2'h0;
   logic [POS_WIDTH-1:0]  hist[$];
   int                    n_errors   = 0;
   int                    compares   = 0;
   int                    n_pulses   = 0;
   int                    n_steps    = 0;
   int                    k, n, gap, found;
   logic                  dir, two;
   wire logic [BYTE_WIDTH-1:0] bus_level;

   always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   quad_link_if quad_link_if_inst ();

   // undriven bus floats
   assign bus_level = quad_link_if_inst.data_oe ? quad_link_if_inst.data : 8'hzz;

   quad_count_device #(.FILT_LEN(FILTER_LEN)) quad_count_device_inst
   (
      .core_clk   (core_clk),
      .reset      (reset),
      .phase_a_in (phase_a_in),
      .phase_b_in (phase_b_in),
      .link       (quad_link_if_inst.dev)
   );

   quad_bus_host #(.EXT_W(EXT_WIDTH)) quad_bus_host_inst
   (
      .core_clk   (core_clk),
      .reset      (reset),
      .read_start (read_start),
      .two_byte   (two_byte),
      .read_done  (read_done),
      .read_pos   (read_pos),
      .read_ext   (read_ext),
      .link       (quad_link_if_inst.host)
   );

   quad_link_props quad_link_props_inst
   (
      .core_clk           (core_clk),
      .reset              (reset),
      .oe_n               (quad_link_if_inst.oe_n),
      .byte_sel           (quad_link_if_inst.byte_sel),
      .data               (quad_link_if_inst.data),
      .data_oe            (quad_link_if_inst.data_oe),
      .decode_count_pulse (quad_link_if_inst.decode_count_pulse),
      .wrap_cascade_pulse (quad_link_if_inst.wrap_cascade_pulse),
      .count_up           (quad_link_if_inst.count_up)
   );

   // pulses sampled mid high phase, clear of both edges
   always @(posedge core_clk)
   begin
      #2;
      if (quad_link_if_inst.decode_count_pulse === 1'b1)
         n_pulses++;
   end

   function automatic logic [1:0] phase_of(logic [1:0] s);
      case (s)
         2'h0: return 2'b00;
         2'h1: return 2'b10;
         2'h2: return 2'b11;
         default: return 2'b01;
      endcase
   endfunction

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task results;
      if (n_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // one quadrature step; a leading b counts up
   task automatic step(input logic up);
      if (up && exp_pos === POS_TOP)
         exp_ext = exp_ext + 8'h01;
      if (!up && exp_pos === POS_BOTTOM)
         exp_ext = exp_ext - 8'h01;
      exp_pos = up ? exp_pos + 16'h0001 : exp_pos - 16'h0001;
      hist.push_back(exp_pos);
      n_steps++;
      state = up ? state + 2'h1 : state - 2'h1;
      {phase_a_in, phase_b_in} <= phase_of(state);
      repeat (4) @(posedge core_clk);
   endtask

   task automatic do_read(input logic tb);
      int i;
      read_start <= 1'b1;
      two_byte   <= tb;
      @(posedge core_clk);
      read_start <= 1'b0;
      for (i = 0; i < 20 && read_done !== 1'b1; i++)
         @(posedge core_clk);
      chk("read finished", 16'h0001, {15'h0, i < 20});
   endtask

   // settled readout must equal the counted position exactly
   task automatic quiet_check(input logic tb);
      repeat (12) @(posedge core_clk);
      chk("bus idle", 16'h00zz, {8'h00, bus_level});
      do_read(tb);
      chk("position", tb ? exp_pos : {8'h00, exp_pos[7:0]}, read_pos);
      if (tb)
         chk("cascade count", {8'h00, exp_ext}, {8'h00, read_ext});
      chk("pulse count", n_steps[15:0], n_pulses[15:0]);
   endtask

   initial
   begin
      n = $urandom(20652);
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      quiet_check(1'b1);
      // underflow then overflow right at zero
      step(1'b0);
      quiet_check(1'b1);
      step(1'b1);
      quiet_check(1'b1);
      for (k = 0; k < 40; k++)
      begin
         dir = 1'($urandom % 2);
         n   = $urandom % 7;
         two = 1'($urandom % 2);
         gap = $urandom % 8;
         hist.delete();
         hist.push_back(exp_pos);
         // read while the encoder keeps moving
         fork
            repeat (n) step(dir);
            begin
               repeat (gap) @(posedge core_clk);
               do_read(two);
            end
         join
         found = 0;
         foreach (hist[i])
            if (read_pos === (two ? hist[i] : {8'h00, hist[i][7:0]}))
               found = 1;
         chk("moving read", 16'h0001, found[15:0]);
         quiet_check(1'($urandom % 2));
      end
      // reset mid-run from a rest phase, so no step is implied
      while (state != 2'h0)
         step(1'b1);
      step(1'b0);
      step(1'b1);
      // reset lands while a two-byte read holds the latch inhibited
      read_start <= 1'b1;
      two_byte   <= 1'b1;
      @(posedge core_clk);
      read_start <= 1'b0;
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      exp_pos  = POS_RESET;
      exp_ext  = EXT_RESET;
      n_steps  = 0;
      n_pulses = 0;
      @(posedge core_clk);
      quiet_check(1'b1);
      results();
   end

   // hang guard, well beyond the longest walk
   initial
   begin
      repeat (30000) @(posedge core_clk);
      n_errors++;
      results();
   end

endmodule // quadrature_count_readout_bench
